/* hdl/cfg_space_defines.svh */
// constants of the configuration-space map and capability registers
`ifndef CFG_SPACE_DEFINES_SVH
`define CFG_SPACE_DEFINES_SVH
// ==========================================================
// configuration space ranges (24-bit byte offsets)
`define CFG_AW               24
`define CFG_DW               32
`define CFG_LOGIC_LAST       24'h0000fc
`define CFG_EXT_FIRST        24'h000100
`define CFG_EXT_LAST         24'h00fffc
`define CFG_IMPL_FIRST       24'h010000
`define CFG_MAINT_INFO_ADDR  24'h010000
// ==========================================================
// capability register offsets
`define CAP_PART_ID          24'h000000
`define CAP_PART_INFO        24'h000004
`define CAP_MODULE_ID        24'h000008
`define CAP_MODULE_INFO      24'h00000c
`define CAP_ELEMENT_FEAT     24'h000010
`define CAP_SWITCH_PORT      24'h000014
`define CAP_SOURCE_OPS       24'h000018
`define CAP_DEST_OPS         24'h00001c
`define CAP_LAST             24'h00003c
// ==========================================================
// field positions
`define PINFO_SPEC_LSB       16
`define PINFO_MAJOR_LSB      8
`define PINFO_MINOR_LSB      4
`define PINFO_PATCH_LSB      0
`define ID_UPPER_LSB         16
// ==========================================================
// host register file over ahb-lite (byte addresses)
`define HREG_CTRL            32'h00000000
`define HREG_ADDR            32'h00000004
`define HREG_WDATA           32'h00000008
`define HREG_STATUS          32'h0000000c
`define HREG_RDATA           32'h00000010
`define HREG_CTRL_GO_BIT     0
`define HREG_CTRL_WR_BIT     1
`define HREG_CTRL_STRB_LSB   4
`define HREG_STAT_BUSY_BIT   0
`define HREG_STAT_DONE_BIT   1
`define HREG_STAT_RESP_LSB   4
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2
`endif

/* hdl/cfg_space_pkg.sv */
// types used by the register-slave end of the configuration port
package cfg_space_pkg;
  typedef enum logic [1:0] {
    UNIT_CAPABILITY,
    UNIT_LOGIC_CSR,
    UNIT_LANE_PROTOCOL,
    UNIT_IMPL
  } cfg_unit_t;
endpackage

/* hdl/cfg_port_if.sv */
// axi4-lite style configuration port between fabric and register slave
`timescale 1ns/1ps
`default_nettype none
interface cfg_port_if;
  logic        awvalid;
  logic        awready;
  logic [23:0] awaddr;
  logic [2:0]  awprot;
  logic        wvalid;
  logic        wready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        bvalid;
  logic        bready;
  logic [1:0]  bresp;
  logic        arvalid;
  logic        arready;
  logic [23:0] araddr;
  logic [2:0]  arprot;
  logic        rvalid;
  logic        rready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  modport fabric (output awvalid, awaddr, awprot, wvalid, wdata, wstrb, bready,
                  arvalid, araddr, arprot, rready,
                  input awready, wready, bvalid, bresp, arready, rvalid, rdata, rresp);
  modport regs   (input awvalid, awaddr, awprot, wvalid, wdata, wstrb, bready,
                  arvalid, araddr, arprot, rready,
                  output awready, wready, bvalid, bresp, arready, rvalid, rdata, rresp);
endinterface
`default_nettype wire

/* hdl/capability_reg_bank.sv */
// capability register slave: read-only capability bank and configuration decode
// ==========================================================
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_space_defines.svh"
module capability_reg_bank #(
  parameter logic [15:0] PART_CODE     = 16'h1234, // arbitrary value
  parameter logic [15:0] VENDOR_CODE   = 16'h5a5a, // arbitrary value
  parameter logic [3:0]  SPEC_LABEL    = 4'h3,     // arbitrary value
  parameter logic [3:0]  MAJOR_REV     = 4'h3,     // arbitrary value
  parameter logic [3:0]  MINOR_REV     = 4'h6,     // arbitrary value
  parameter logic [3:0]  PATCH_LEVEL   = 4'h7,     // arbitrary value
  parameter logic [15:0] MODULE_CODE   = 16'h0000, // arbitrary value
  parameter logic [15:0] MODULE_VENDOR = 16'h0000, // arbitrary value
  parameter logic [31:0] MODULE_INFO   = 32'h01000000,
  parameter logic [31:0] ELEMENT_FEAT  = 32'h00000009,
  parameter logic [31:0] SOURCE_OPS    = 32'h00000000,
  parameter logic [31:0] DEST_OPS      = 32'h00000000,
  parameter bit          MAINT_PORT    = 1'b1
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  cfg_port_if.regs         port,
  input  wire logic        i_maint_valid,
  input  wire logic        i_maint_write,
  input  wire logic [31:0] i_maint_wdata,
  output logic      [31:0] o_maint_info,
  output logic             o_ext_hit,
  output logic             o_impl_hit
);

  // ==========================================================
  // state of the slave, registered as one word
  typedef struct packed {
    logic        aw_full;
    logic [23:0] aw_addr;
    logic        w_full;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [31:0] maint_info;
    logic        ext_hit;
    logic        impl_hit;
    logic        aw_ready;
    logic        w_ready;
    logic        ar_ready;
  } state_t;

  // state copy, read-side decode and the fixed word table
  state_t s_q;
  state_t s_d;
  cfg_space_pkg::cfg_unit_t rd_unit;
  logic [31:0] rd_word;
  logic [31:0] cap_word [8];
  cfg_space_pkg::cfg_unit_t wr_unit;

  // ==========================================================
  // address decode into sub-unit ranges
  function automatic cfg_space_pkg::cfg_unit_t unit_of(input logic [23:0] a);
    if (a <= `CAP_LAST) begin
      unit_of = cfg_space_pkg::UNIT_CAPABILITY;
    end else if (a <= `CFG_LOGIC_LAST) begin
      unit_of = cfg_space_pkg::UNIT_LOGIC_CSR;
    end else if (a <= `CFG_EXT_LAST) begin
      unit_of = cfg_space_pkg::UNIT_LANE_PROTOCOL;
    end else begin
      unit_of = cfg_space_pkg::UNIT_IMPL;
    end
  endfunction

  // ==========================================================
  // fixed capability words, one slot per register, no write path
  always_comb begin
    cap_word[0] = {PART_CODE, VENDOR_CODE};
    cap_word[1] = {12'h000, SPEC_LABEL, 4'h0, MAJOR_REV,
                   MINOR_REV, PATCH_LEVEL};
    cap_word[2] = {MODULE_CODE, MODULE_VENDOR};
    cap_word[3] = MODULE_INFO;
    cap_word[4] = ELEMENT_FEAT;
    cap_word[5] = 32'h00000000; // no switch ports behind this endpoint
    cap_word[6] = SOURCE_OPS;
    cap_word[7] = DEST_OPS;
  end

  // ==========================================================
  // capability read mux; reserved and foreign words read zero
  always_comb begin
    rd_unit = unit_of(port.araddr);
    rd_word = 32'h00000000;
    if (rd_unit == cfg_space_pkg::UNIT_CAPABILITY) begin
      case ({port.araddr[23:2], 2'b00})
        `CAP_PART_ID:      rd_word = cap_word[0];
        `CAP_PART_INFO:    rd_word = cap_word[1];
        `CAP_MODULE_ID:    rd_word = cap_word[2];
        `CAP_MODULE_INFO:  rd_word = cap_word[3];
        `CAP_ELEMENT_FEAT: rd_word = cap_word[4];
        `CAP_SWITCH_PORT:  rd_word = cap_word[5];
        `CAP_SOURCE_OPS:   rd_word = cap_word[6];
        `CAP_DEST_OPS:     rd_word = cap_word[7];
        default:           rd_word = 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // unit of the write address held in the capture register
  always_comb begin
    wr_unit = unit_of(s_q.aw_addr);
  end

  // ==========================================================
  // next-state logic for both channels
  always_comb begin
    s_d = s_q;
    s_d.ext_hit = 1'b0;
    s_d.impl_hit = 1'b0;
    // write address captured and write data accepted (not stored) independently, each only while its
    // ready flop is up so the fabric sees the same handshake we act on
    if (port.awvalid && s_q.aw_ready) begin
      s_d.aw_full = 1'b1;
      s_d.aw_addr = port.awaddr;
    end
    if (port.wvalid && s_q.w_ready) begin
      s_d.w_full = 1'b1;
    end
    // both halves present: answer, capability contents untouched
    if (s_q.aw_full && s_q.w_full && !s_q.bvalid) begin
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `RESP_OKAY;
      // one-cycle pulses name the unit that the discarded write aimed at
      s_d.ext_hit = (wr_unit == cfg_space_pkg::UNIT_LANE_PROTOCOL);
      s_d.impl_hit = (wr_unit == cfg_space_pkg::UNIT_IMPL);
    end
    if (s_q.bvalid && port.bready) begin
      s_d.bvalid = 1'b0;
    end
    // read accepted when no response is pending
    if (port.arvalid && s_q.ar_ready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_word;
      s_d.rresp = `RESP_OKAY;
      // maintenance info is never visible through this port
      if (port.araddr == `CFG_MAINT_INFO_ADDR) begin
        s_d.rdata = 32'h00000000;
      end
    end else if (s_q.rvalid && port.rready) begin
      s_d.rvalid = 1'b0;
    end
    // maintenance path alone may update the information register
    // without the maintenance port the register keeps its reset value
    if (MAINT_PORT && i_maint_valid && i_maint_write) begin
      s_d.maint_info = i_maint_wdata;
    end
    // readies leave flops: they follow the free state one edge ahead,
    // so they are low in reset and rise at the first edge after release
    s_d.aw_ready = !s_d.aw_full;
    s_d.w_ready = !s_d.w_full;
    s_d.ar_ready = !s_d.rvalid;
  end

  // ==========================================================
  // state register
  // all valids, readies and captured data clear while reset holds
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // port outputs, every one straight from the state register
  assign port.awready = s_q.aw_ready;
  assign port.wready  = s_q.w_ready;
  assign port.bvalid  = s_q.bvalid;
  assign port.bresp   = s_q.bresp;
  assign port.arready = s_q.ar_ready;
  assign port.rvalid  = s_q.rvalid;
  assign port.rdata   = s_q.rdata;
  assign port.rresp   = s_q.rresp;

  // side outputs toward the maintenance path and system decode
  assign o_maint_info = s_q.maint_info;
  assign o_ext_hit    = s_q.ext_hit;
  assign o_impl_hit   = s_q.impl_hit;

endmodule
`default_nettype wire

/* hdl/cfg_fabric_master.sv */
// configuration fabric master: ahb-lite registers drive one port transfer
`timescale 1ns/1ps
`default_nettype none
`include "cfg_space_defines.svh"
module cfg_fabric_master (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  cfg_port_if.fabric       port
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WRITE,
    ST_READ
  } fsm_t;

  typedef struct packed {
    fsm_t        fsm;
    logic        dph;
    logic        dwr;
    logic [7:0]  dadr;
    logic [31:0] hrdata;
    logic [23:0] addr;
    logic [31:0] wdata;
    logic [3:0]  strb;
    logic        busy;
    logic        done;
    logic [1:0]  resp;
    logic [31:0] rdata;
    logic        awvalid;
    logic        wvalid;
    logic        bready;
    logic        arvalid;
    logic        rready;
  } state_t;

  state_t s_q;
  state_t s_d;

  // ==========================================================
  // ahb slave and port sequencing
  always_comb begin
    s_d = s_q;
    // address phase capture, zero wait states
    s_d.dph = i_hsel && i_hready && i_htrans[1];
    if (s_d.dph) begin
      s_d.dwr = i_hwrite;
      s_d.dadr = i_haddr[7:0];
    end
    // data phase write into control registers
    if (s_q.dph && s_q.dwr) begin
      case ({24'h000000, s_q.dadr})
        `HREG_ADDR:  s_d.addr = i_hwdata[23:0];
        `HREG_WDATA: s_d.wdata = i_hwdata;
        `HREG_CTRL: begin
          if (i_hwdata[`HREG_CTRL_GO_BIT] && !s_q.busy) begin
            s_d.busy = 1'b1;
            s_d.done = 1'b0;
            s_d.strb = i_hwdata[`HREG_CTRL_STRB_LSB +: 4];
            if (i_hwdata[`HREG_CTRL_WR_BIT]) begin
              s_d.fsm = ST_WRITE;
              s_d.awvalid = 1'b1;
              s_d.wvalid = 1'b1;
              s_d.bready = 1'b1;
            end else begin
              s_d.fsm = ST_READ;
              s_d.arvalid = 1'b1;
              s_d.rready = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end
    // read data for next data phase
    if (s_d.dph && !i_hwrite) begin
      case ({24'h000000, i_haddr[7:0]})
        `HREG_ADDR:   s_d.hrdata = {8'h00, s_q.addr};
        `HREG_WDATA:  s_d.hrdata = s_q.wdata;
        `HREG_STATUS: s_d.hrdata = {26'h0, s_q.resp, 2'b00, s_q.done, s_q.busy};
        `HREG_RDATA:  s_d.hrdata = s_q.rdata;
        default:      s_d.hrdata = 32'h00000000;
      endcase
    end
    // port handshakes hold until accepted
    case (s_q.fsm)
      ST_WRITE: begin
        if (s_q.awvalid && port.awready) s_d.awvalid = 1'b0;
        if (s_q.wvalid && port.wready) s_d.wvalid = 1'b0;
        if (s_q.bready && port.bvalid) begin
          s_d.bready = 1'b0;
          s_d.resp = port.bresp;
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
          s_d.fsm = ST_IDLE;
        end
      end
      ST_READ: begin
        if (s_q.arvalid && port.arready) s_d.arvalid = 1'b0;
        if (s_q.rready && port.rvalid && !s_q.arvalid) begin
          s_d.rready = 1'b0;
          s_d.rdata = port.rdata;
          s_d.resp = port.rresp;
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
          s_d.fsm = ST_IDLE;
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  assign o_hrdata     = s_q.hrdata;
  assign o_hreadyout  = 1'b1;
  assign o_hresp      = 1'b0;
  assign port.awvalid = s_q.awvalid;
  assign port.awaddr  = s_q.addr;
  assign port.awprot  = 3'h0;
  assign port.wvalid  = s_q.wvalid;
  assign port.wdata   = s_q.wdata;
  assign port.wstrb   = s_q.strb;
  assign port.bready  = s_q.bready;
  assign port.arvalid = s_q.arvalid;
  assign port.araddr  = s_q.addr;
  assign port.arprot  = 3'h0;
  assign port.rready  = s_q.rready;

endmodule
`default_nettype wire

/* dv/cfg_port_monitor.sv */
// protocol and register-map checker for the configuration port
`timescale 1ns/1ps
`default_nettype none
module cfg_port_monitor (
  input wire logic        i_core_clk,
  input wire logic        i_rst_n,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [23:0] awaddr,
  input wire logic [2:0]  awprot,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0]  wstrb,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [23:0] araddr,
  input wire logic [2:0]  arprot,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata
);
  logic [23:0] ar_q;
  // ==========================================================
  // address of the read in flight
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) ar_q <= 24'h000000;
    else if (arvalid && arready) ar_q <= araddr;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // ==========================================================
  // handshake holding and response timing
  property p_aw_hold;
    awvalid && !awready |=> awvalid && $stable(awaddr);
  endproperty
  a_aw_hold: assert property (p_aw_hold) else $error("write address dropped");
  property p_awprot;
    awvalid |-> awprot == 3'h0;
  endproperty
  a_awprot: assert property (p_awprot) else $error("write protection not zero");
  property p_w_hold;
    wvalid && !wready |=> wvalid && $stable(wdata) && $stable(wstrb);
  endproperty
  a_w_hold: assert property (p_w_hold) else $error("write data dropped");
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_b_time;
    awvalid && awready && wvalid && wready |-> ##[1:2] bvalid;
  endproperty
  a_b_time: assert property (p_b_time) else $error("write response late");
  property p_ar_hold;
    arvalid && !arready |=> arvalid && $stable(araddr) && arprot == 3'h0;
  endproperty
  a_ar_hold: assert property (p_ar_hold) else $error("read address dropped");
  property p_r_next;
    arvalid && arready |=> rvalid && !arready;
  endproperty
  a_r_next: assert property (p_r_next) else $error("read data late");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  // ==========================================================
  // register map contents
  property p_res_zero;
    rvalid && ar_q >= 24'h000020 && ar_q <= 24'h00003c |-> rdata == 32'h00000000;
  endproperty
  a_res_zero: assert property (p_res_zero) else $error("reserved word not zero");
  property p_info_res;
    rvalid && ar_q == 24'h000004 |-> rdata[31:20] == 12'h000 && rdata[15:12] == 4'h0;
  endproperty
  a_info_res: assert property (p_info_res) else $error("info reserved bits set");
  property p_maint_hidden;
    rvalid && ar_q == 24'h010000 |-> rdata == 32'h00000000;
  endproperty
  a_maint_hidden: assert property (p_maint_hidden) else $error("maintenance info visible");
  property p_b_okay;
    bvalid |-> bresp == 2'h0;
  endproperty
  a_b_okay: assert property (p_b_okay) else $error("write response not okay");
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// testbench: ahb host drives the fabric master into the capability bank
`timescale 1ns/1ps
`default_nettype none
`include "cfg_space_defines.svh"
module tb_top;
  // expected capability words, vendor fields arbitrary
  localparam logic [31:0] CAP [8] = '{32'h4c2100a7, 32'h00060847, 32'h3b100c5d,
    32'h00070100, 32'h60000009, 32'h00000000, 32'h0000fc00, 32'h0000f000};
  logic        i_core_clk, i_rst_n, hsel, hwrite, mvalid, mwrite, hreadyout, hresp;
  logic        ext_hit, impl_hit;
  logic [31:0] haddr, hwdata, hrdata, mwdata, minfo, q, d, seed;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] exp_q[$];
  logic [1:0]  resp_q[$];
  int          miscompares, cmp_count, n_ext, n_impl;
  cfg_port_if bus ();
  cfg_fabric_master i_cfg_fabric_master (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout),
    .o_hresp(hresp), .port(bus.fabric));
  capability_reg_bank #(.PART_CODE(CAP[0][31:16]), .VENDOR_CODE(CAP[0][15:0]),
    .SPEC_LABEL(CAP[1][19:16]), .MAJOR_REV(CAP[1][11:8]), .MINOR_REV(CAP[1][7:4]),
    .PATCH_LEVEL(CAP[1][3:0]), .MODULE_CODE(CAP[2][31:16]), .MODULE_VENDOR(CAP[2][15:0]),
    .MODULE_INFO(CAP[3]), .ELEMENT_FEAT(CAP[4]), .SOURCE_OPS(CAP[6]), .DEST_OPS(CAP[7]),
    .MAINT_PORT(1'b1)) i_capability_reg_bank (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .port(bus.regs), .i_maint_valid(mvalid), .i_maint_write(mwrite), .i_maint_wdata(mwdata),
    .o_maint_info(minfo), .o_ext_hit(ext_hit), .o_impl_hit(impl_hit));
  cfg_port_monitor i_mon (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .awvalid(bus.awvalid), .awready(bus.awready), .awaddr(bus.awaddr), .awprot(bus.awprot),
    .wvalid(bus.wvalid), .wready(bus.wready), .wdata(bus.wdata), .wstrb(bus.wstrb),
    .bvalid(bus.bvalid), .bready(bus.bready), .bresp(bus.bresp), .arvalid(bus.arvalid),
    .arready(bus.arready), .araddr(bus.araddr), .arprot(bus.arprot), .rvalid(bus.rvalid),
    .rready(bus.rready), .rdata(bus.rdata));
  // 25 mhz clock
  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    cmp(32'(got), 32'(exp));
  endtask
  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // bounded wait for hready at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      miscompares++;
      end_of_test();
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    @(posedge i_core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    r = hrdata;
  endtask
  // one port transfer through the host registers, polled to completion
  task automatic op(input logic wr, input logic [23:0] a, input logic [31:0] wd,
                    input logic [3:0] s);
    int n;
    logic [31:0] r;
    ahb(1'b1, `HREG_ADDR, {8'h00, a}, r);
    ahb(1'b1, `HREG_WDATA, wd, r);
    ahb(1'b1, `HREG_CTRL, {24'h000000, s, 2'b00, wr, 1'b1}, r);
    n = 0;
    do begin
      ahb(1'b0, `HREG_STATUS, 32'h00000000, r);
      n++;
    end while (!(r[0] === 1'b0 && r[1] === 1'b1) && n < 32);
    if (!(r[1] === 1'b1)) begin
      miscompares++;
      end_of_test();
    end
    cmp_resp(r[5:4], `RESP_OKAY);
    cmp_resp({1'b0, hresp}, 2'h0);
  endtask
  task automatic rd(input logic [23:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    op(1'b0, a, 32'h00000000, 4'h0);
    ahb(1'b0, `HREG_RDATA, 32'h00000000, q);
    cmp(q, e);
  endtask
  task automatic wr(input logic [23:0] a, input logic [31:0] wd);
    resp_q.push_back(`RESP_OKAY);
    op(1'b1, a, wd, 4'(seed));
  endtask
  // port results against the oldest expectation, hit pulses counted
  always @(posedge i_core_clk) begin
    if (i_rst_n === 1'b1) begin
      if (bus.rvalid === 1'b1 && bus.rready === 1'b1) cmp(bus.rdata, exp_q.pop_front());
      if (bus.bvalid === 1'b1 && bus.bready === 1'b1) cmp_resp(bus.bresp, resp_q.pop_front());
      if (ext_hit === 1'b1) n_ext++;
      if (impl_hit === 1'b1) n_impl++;
    end
  end
  // main sequence
  initial begin
    seed = 32'h2be34c67;
    {i_rst_n, hsel, hwrite, mvalid, mwrite, htrans, haddr, hwdata, mwdata} = '0;
    hsize = 3'h2;
    repeat (6) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(24'(4 * i), CAP[i]);
      d = $random(seed);
      wr(24'(4 * i), d);
      rd(24'(4 * i), CAP[i]);
    end
    for (int i = 8; i < 16; i++) rd(24'(4 * i), 32'h00000000);
    wr(`CFG_EXT_FIRST, $random(seed));
    wr(`CFG_EXT_LAST, $random(seed));
    wr(`CFG_LOGIC_LAST, $random(seed));
    rd(`CFG_LOGIC_LAST, 32'h00000000);
    wr(24'h010004, $random(seed));
    cmp(32'(n_ext), 32'h00000002);
    cmp(32'(n_impl), 32'h00000001);
    d = $random(seed);
    @(posedge i_core_clk);
    mvalid <= 1'b1;
    mwrite <= 1'b1;
    mwdata <= d;
    @(posedge i_core_clk);
    mvalid <= 1'b0;
    mwrite <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    cmp(minfo, d);
    rd(`CFG_MAINT_INFO_ADDR, 32'h00000000);
    wr(`CFG_MAINT_INFO_ADDR, ~d);
    cmp(minfo, d);
    ahb(1'b0, 32'h00000014, 32'h00000000, q);
    cmp(q, 32'h00000000);
    end_of_test();
  end
endmodule
`default_nettype wire
